// >>> tb_tmc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tmc_timer;
    import tmc_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic io_space_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic global_irq_en_i = 1'b0;
    logic [2:0] irq_ack_i = 3'h0;
    logic [7:0] rdata_o;
    logic [2:0] irq_o;
    logic cpin, wave_a, wave_b, over_a, over_b, pin_b;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    int h, x;
    logic [31:0] rnd_s = 32'h454e;
    logic [7:0] d, e;
    logic [1:0] fm [5] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h0};
    logic fx [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    int divs [6] = '{1, 1, TMC_DIV_8, TMC_DIV_64, TMC_DIV_256, TMC_DIV_1024};
    always #5 clk_i = ~clk_i;
    tmc_timer tmc_timer_i (
        .clk_i, .srst_i, .addr_i, .io_space_i, .wr_i, .rd_i, .wdata_i,
        .rdata_o, .global_irq_en_i, .irq_ack_i, .irq_o,
        .external_count_pin_i(cpin), .wave_out_a_o(wave_a),
        .wave_out_b_o(wave_b), .wave_a_override_o(over_a),
        .wave_b_override_o(over_b)
    );
    tmc_pin_model tmc_pin_model_i (
        .clk_i, .wave_b_i(wave_b), .override_b_i(over_b), .pin_b_o(pin_b),
        .count_pin_o(cpin)
    );
    function automatic logic [7:0] rnd();
        rnd_s ^= rnd_s << 13;
        rnd_s ^= rnd_s >> 17;
        rnd_s ^= rnd_s << 5;
        return rnd_s[7:0];
    endfunction
    // High samples of the pin over two periods, after inversion when inv is set.
    function automatic int pwm_high(input logic ph, input logic inv,
                                    input logic [7:0] ocr);
        int hi;
        hi = ph ? 4 * ocr : 2 * (ocr + 1);
        return inv ? (ph ? 1020 : 512) - hi : hi;
    endfunction
    task automatic end_sim();
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] v);
        @(negedge clk_i);
        addr_i = a;
        io_space_i = io;
        wdata_i = v;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic io,
                      output logic [7:0] v);
        @(negedge clk_i);
        addr_i = a;
        io_space_i = io;
        rd_i = 1'b1;
        @(negedge clk_i);
        rd_i = 1'b0;
        @(negedge clk_i);
        v = rdata_o;
    endtask
    // The two reads are taken exactly k clocks apart.
    task automatic cnt_delta(input int k, output logic [7:0] dv);
        logic [7:0] a0, a1;
        rd(TMC_ADDR_CNT, 1'b0, a0);
        repeat (k - 3) @(negedge clk_i);
        rd(TMC_ADDR_CNT, 1'b0, a1);
        dv = a1 - a0;
    endtask
    task automatic wait_ovf();
        for (int j = 0; j < 300 && irq_o[0] !== 1'b1; j++) @(negedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        srst_i = 1'b0;
        rd(TMC_ADDR_CTRL_A, 1'b0, d);
        chk(d, 8'h00);
        rd(TMC_ADDR_CTRL_B, 1'b0, d);
        chk(d, 8'h00);
        chk({6'h00, wave_a, wave_b}, 8'h00);
        cnt_delta(20, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            e = rnd();
            wr(i[0] ? 8'h27 : TMC_ADDR_OCRB, i[0], e);
            rd(i[0] ? TMC_ADDR_OCRA : 8'h28, ~i[0], d);
            chk(d, e);
        end
        wr(TMC_ADDR_MASK, 1'b0, 8'hff);
        rd(TMC_ADDR_MASK, 1'b0, d);
        chk(d, 8'h07);
        for (int i = 0; i < 5; i++) begin
            wr(8'h24, 1'b1, {2'b00, fm[i], 4'h0});
            wr(TMC_ADDR_CTRL_B, 1'b0, 8'h40);
            repeat (2) @(negedge clk_i);
            chk({6'h00, wave_b, over_b}, {6'h00, fx[i], fm[i] != 2'h0});
        end
        wr(TMC_ADDR_CTRL_A, 1'b0, 8'hc0);
        wr(TMC_ADDR_CTRL_B, 1'b0, 8'h80);
        repeat (2) @(negedge clk_i);
        chk({6'h00, wave_a, over_a}, 8'h03);
        rd(TMC_ADDR_CTRL_B, 1'b0, d);
        chk(d, 8'h00);
        rd(TMC_ADDR_FLAG, 1'b0, d);
        chk(d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(8'h25, 1'b1, {5'h00, i[2:0]});
            cnt_delta(20 * divs[i], d);
            chk(d, (i == 0) ? 8'h00 : 8'h14);
        end
        for (int i = 0; i < 4; i++) begin
            wr(TMC_ADDR_CTRL_B, 1'b0, {7'h03, i[1]});
            rd(TMC_ADDR_CNT, 1'b0, e);
            tmc_pin_model_i.drive(~i[0], 6);
            rd(TMC_ADDR_CNT, 1'b0, d);
            chk(d - e, {7'h00, i[1] ^ i[0]});
        end
        wr(TMC_ADDR_CTRL_A, 1'b0, 8'h02);
        wr(TMC_ADDR_OCRA, 1'b0, 8'h09);
        wr(TMC_ADDR_CNT, 1'b0, 8'h00);
        wr(TMC_ADDR_CTRL_B, 1'b0, 8'h01);
        for (int i = 0; i < 6; i++) begin
            e = rnd();
            repeat (e[3:0]) @(negedge clk_i);
            rd(TMC_ADDR_CNT, 1'b0, d);
            chk({7'h00, d > 8'h09}, 8'h00);
        end
        wr(TMC_ADDR_CTRL_A, 1'b0, 8'h00);
        wr(TMC_ADDR_CNT, 1'b0, 8'hf0);
        global_irq_en_i = 1'b1;
        wait_ovf();
        chk({7'h00, irq_o[0]}, 8'h01);
        irq_ack_i = 3'h7;
        @(negedge clk_i);
        irq_ack_i = 3'h0;
        repeat (2) @(negedge clk_i);
        chk({7'h00, irq_o[0]}, 8'h00);
        wait_ovf();
        chk({7'h00, irq_o[0]}, 8'h01);
        global_irq_en_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({7'h00, irq_o[0]}, 8'h00);
        wr(8'h15, 1'b1, 8'h01);
        rd(TMC_ADDR_FLAG, 1'b0, d);
        chk({7'h00, d[0]}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            e = rnd() & 8'h7f;
            e = (i < 2) ? 8'hff : e + 8'h10;
            wr(TMC_ADDR_CTRL_B, 1'b0, 8'h00);
            wr(TMC_ADDR_CTRL_A, 1'b0, {2'b00, i[2], 3'b000, ~i[0], 1'b1});
            wr(TMC_ADDR_CTRL_A, 1'b0, {3'b001, i[2], 2'b00, ~i[0], 1'b1});
            wr(TMC_ADDR_OCRB, 1'b0, e);
            wr(TMC_ADDR_CTRL_B, 1'b0, 8'h01);
            repeat (600) @(negedge clk_i);
            h = 0;
            for (int j = 0; j < (i[0] ? 1020 : 512); j++) begin
                @(negedge clk_i);
                h += int'(pin_b);
            end
            x = pwm_high(i[0], i[2], e);
            n_tests++;
            if (h > x + 8 || h + 8 < x) begin
                err_total++;
                $display("mismatch t=%0t got=%h exp=%h", $time, h, x);
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire

// >>> tmc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_edge_sync (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic rise;
        logic fall;
    } tmc_edge_s;

    tmc_edge_s r_reg;
    tmc_edge_s r_next;

    // The first stage feeds only the second stage.
    always_comb begin
        r_next = r_reg;
        r_next.meta = pin_i;
        r_next.sync = r_reg.meta;
        r_next.prev = r_reg.sync;
        r_next.rise = r_reg.sync & ~r_reg.prev;
        r_next.fall = ~r_reg.sync & r_reg.prev;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rise_o = r_reg.rise;
    assign fall_o = r_reg.fall;
endmodule
`default_nettype wire

// >>> tmc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model (
    input wire logic clk_i,
    input wire logic wave_b_i,
    input wire logic override_b_i,
    output logic pin_b_o,
    output logic count_pin_o
);
    // A pin left to its port function idles at the pull-up level.
    assign pin_b_o = override_b_i ? wave_b_i : 1'b1;
    initial count_pin_o = 1'b0;
    // Software drives the count pin like any output, so edges come slowly.
    task automatic drive(input logic lvl, input int hold);
        @(negedge clk_i);
        count_pin_o = lvl;
        repeat (hold) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// >>> tmc_pkg.sv
// Notes on behaviour
// - Non-PWM: channel-B mode 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: B mode 10 clears on match, sets at BOTTOM; 11 inverse; 01 off.
// - Phase PWM: B mode 10 clears on up-match, sets on down-match; 11 inverse.
// - PWM: B compare equal to TOP with high mode bit: match ignored, action at TOP.
// - Phase PWM: A compare equal to TOP with high mode bit: action at TOP.
// - Nonzero B mode overrides the pin; software sets the direction bit too.
// - Wave modes 0,1,2,3,5,7 decode to their counting style and TOP source.
// - Compare update point and overflow flag point follow the wave mode.
// - Force bit in non-PWM mode applies the channel action immediately.
// - Forced compare raises no flag and never clears the counter.
// - Force bits always read back as zero.
// - Clock select 000 stops, 001 undivided, 010-101 divide 8/64/256/1024.
// - Clock select 110 counts falling, 111 rising edges of the count pin.
// - Count pin edges advance the counter even when the pin is an output.
// - Registers answer at data offset; all but the mask also at I/O address 0x20 lower.
// - Mask bit with global enable raises interrupt while its flag is set.
// - Flags clear on vector acknowledge or on software writing one.
// - Counter write suppresses compare match on the next timer clock.
`default_nettype none
package tmc_pkg;
    localparam logic [7:0] TMC_ADDR_CTRL_A = 8'h44;
    localparam logic [7:0] TMC_ADDR_CTRL_B = 8'h45;
    localparam logic [7:0] TMC_ADDR_CNT = 8'h46;
    localparam logic [7:0] TMC_ADDR_OCRA = 8'h47;
    localparam logic [7:0] TMC_ADDR_OCRB = 8'h48;
    localparam logic [7:0] TMC_ADDR_FLAG = 8'h35;
    localparam logic [7:0] TMC_ADDR_MASK = 8'h6e;
    localparam logic [7:0] TMC_IO_OFFSET = 8'h20;
    localparam logic [7:0] TMC_IO_LIMIT = 8'h3f;

    localparam int TMC_COMA_LO = 6;
    localparam int TMC_COMB_LO = 4;
    localparam int TMC_FOCA_BIT = 7;
    localparam int TMC_FOCB_BIT = 6;
    localparam int TMC_WGM2_BIT = 3;
    localparam int TMC_FLAG_OVF = 0;
    localparam int TMC_FLAG_MA = 1;
    localparam int TMC_FLAG_MB = 2;

    localparam logic [7:0] TMC_CTRL_A_RESET = 8'h00;
    localparam logic [3:0] TMC_CTRL_B_RESET = 4'h0;
    localparam logic [7:0] TMC_BYTE_RESET = 8'h00;
    localparam logic [2:0] TMC_BITS3_RESET = 3'h0;
    localparam logic [7:0] TMC_MAX = 8'hff;
    localparam logic [7:0] TMC_BOTTOM = 8'h00;

    localparam int TMC_DIV_8 = 8;
    localparam int TMC_DIV_64 = 64;
    localparam int TMC_DIV_256 = 256;
    localparam int TMC_DIV_1024 = 1024;

    localparam logic [2:0] TMC_CS_STOP = 3'h0;
    localparam logic [2:0] TMC_CS_DIV1 = 3'h1;
    localparam logic [2:0] TMC_CS_DIV8 = 3'h2;
    localparam logic [2:0] TMC_CS_DIV64 = 3'h3;
    localparam logic [2:0] TMC_CS_DIV256 = 3'h4;
    localparam logic [2:0] TMC_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TMC_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TMC_CS_EXT_RISE = 3'h7;

    localparam logic [2:0] TMC_WM_NORMAL = 3'h0;
    localparam logic [2:0] TMC_WM_PC_MAX = 3'h1;
    localparam logic [2:0] TMC_WM_CLEAR = 3'h2;
    localparam logic [2:0] TMC_WM_FAST_MAX = 3'h3;
    localparam logic [2:0] TMC_WM_PC_OCR = 3'h5;
    localparam logic [2:0] TMC_WM_FAST_OCR = 3'h7;

    typedef enum logic [1:0] {
        TMC_CLS_PLAIN = 2'b00,
        TMC_CLS_FAST = 2'b01,
        TMC_CLS_PHASE = 2'b10
    } tmc_class_e;

    // Reserved modes 4 and 6 behave as plain counting.
    function automatic tmc_class_e tmc_wave_class(input logic [2:0] wm);
        tmc_class_e c;
        c = TMC_CLS_PLAIN;
        if (wm == TMC_WM_PC_MAX || wm == TMC_WM_PC_OCR) begin
            c = TMC_CLS_PHASE;
        end else if (wm == TMC_WM_FAST_MAX || wm == TMC_WM_FAST_OCR) begin
            c = TMC_CLS_FAST;
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// >>> tmc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_prescaler #(
    parameter int WIDTH = 10
) (
    input wire logic clk_i,
    input wire logic srst_i,
    output logic tick8_o,
    output logic tick64_o,
    output logic tick256_o,
    output logic tick1024_o
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic [3:0] tick;
    } tmc_presc_s;

    tmc_presc_s r_reg;
    tmc_presc_s r_next;

    function automatic logic div_hit(input logic [WIDTH-1:0] c,
                                     input int div);
        logic [WIDTH-1:0] m;
        m = WIDTH'(div - 1);
        return (c & m) == m;
    endfunction

    always_comb begin
        r_next = r_reg;
        r_next.cnt = r_reg.cnt + 1'b1;
        r_next.tick[0] = div_hit(r_reg.cnt, TMC_DIV_8);
        r_next.tick[1] = div_hit(r_reg.cnt, TMC_DIV_64);
        r_next.tick[2] = div_hit(r_reg.cnt, TMC_DIV_256);
        r_next.tick[3] = div_hit(r_reg.cnt, TMC_DIV_1024);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick8_o = r_reg.tick[0];
    assign tick64_o = r_reg.tick[1];
    assign tick256_o = r_reg.tick[2];
    assign tick1024_o = r_reg.tick[3];
endmodule
`default_nettype wire

// >>> tmc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_timer (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic io_space_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic global_irq_en_i,
    input wire logic [2:0] irq_ack_i,
    output logic [2:0] irq_o,
    input wire logic external_count_pin_i,
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic wave_a_override_o,
    output logic wave_b_override_o
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [3:0] ctrl_b;
        logic [7:0] cnt;
        logic [7:0] ocra_buf;
        logic [7:0] ocrb_buf;
        logic [7:0] ocra;
        logic [7:0] ocrb;
        logic [2:0] flags;
        logic [2:0] mask;
        logic dir_down;
        logic blk;
        logic out_a;
        logic out_b;
        logic en_a;
        logic en_b;
        logic [2:0] irq;
        logic [7:0] rdata;
    } tmc_state_s;

    tmc_state_s r_reg;
    tmc_state_s r_next;

    logic t8, t64, t256, t1024, ext_rise, ext_fall;

    tmc_prescaler #(
        .WIDTH(10)
    ) u_presc (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick8_o(t8),
        .tick64_o(t64),
        .tick256_o(t256),
        .tick1024_o(t1024)
    );

    // The pin is watched regardless of its direction setting.
    tmc_edge_sync u_edge (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(external_count_pin_i),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // Next level of one wave output for every mode style.
    function automatic logic wave_next(
        input logic [1:0] com,
        input logic tog_ok,
        input tmc_class_e cls,
        input logic cur,
        input logic hit,
        input logic frc,
        input logic at_top,
        input logic up,
        input logic ocr_top
    );
        logic v;
        v = cur;
        unique case (cls)
            TMC_CLS_PLAIN: begin
                if (hit || frc) begin
                    unique case (com)
                        2'b00: v = cur;
                        2'b01: v = ~cur;
                        2'b10: v = 1'b0;
                        2'b11: v = 1'b1;
                    endcase
                end
            end
            TMC_CLS_FAST: begin
                if (com[1]) begin
                    if (ocr_top) begin
                        if (at_top) begin
                            v = ~com[0];
                        end
                    end else begin
                        if (at_top) begin
                            v = ~com[0];
                        end
                        if (hit) begin
                            v = com[0];
                        end
                    end
                end else if (com[0] && tog_ok && hit) begin
                    v = ~cur;
                end
            end
            TMC_CLS_PHASE: begin
                if (com[1]) begin
                    if (ocr_top) begin
                        if (at_top) begin
                            v = ~com[0];
                        end
                    end else if (hit) begin
                        v = up ? com[0] : ~com[0];
                    end
                end else if (com[0] && tog_ok && hit) begin
                    v = ~cur;
                end
            end
            default: v = cur;
        endcase
        return v;
    endfunction

    logic [7:0] eff_addr;
    logic addr_ok;
    logic [2:0] wmode;
    tmc_class_e cls;
    logic [7:0] top;
    logic tick, at_top, hit_a, hit_b, ovf_at, frc_a, frc_b;
    logic [2:0] flag_clr, flag_set;
    logic wr_cnt;
    logic [2:0] cs;

    always_comb begin
        // I/O space sits 0x20 below data space and only covers 0x00-0x3f.
        eff_addr = addr_i + TMC_IO_OFFSET;
        addr_ok = (addr_i <= TMC_IO_LIMIT);
        if (!io_space_i) begin
            eff_addr = addr_i;
            addr_ok = 1'b1;
        end
        wmode = {r_reg.ctrl_b[TMC_WGM2_BIT], r_reg.ctrl_a[1:0]};
        cls = tmc_wave_class(wmode);
        // Reserved codes 4 and 6 keep the full 8-bit range.
        top = TMC_MAX;
        if (wmode == TMC_WM_CLEAR || wmode == TMC_WM_PC_OCR
            || wmode == TMC_WM_FAST_OCR) begin
            top = r_reg.ocra;
        end
        cs = r_reg.ctrl_b[2:0];
        unique case (cs)
            TMC_CS_STOP: tick = 1'b0;
            TMC_CS_DIV1: tick = 1'b1;
            TMC_CS_DIV8: tick = t8;
            TMC_CS_DIV64: tick = t64;
            TMC_CS_DIV256: tick = t256;
            TMC_CS_DIV1024: tick = t1024;
            TMC_CS_EXT_FALL: tick = ext_fall;
            TMC_CS_EXT_RISE: tick = ext_rise;
        endcase
        at_top = tick && (r_reg.cnt == top);
        hit_a = tick && !r_reg.blk && (r_reg.cnt == r_reg.ocra);
        hit_b = tick && !r_reg.blk && (r_reg.cnt == r_reg.ocrb);
        if (cls == TMC_CLS_PHASE) begin
            ovf_at = tick && r_reg.dir_down && (r_reg.cnt == TMC_BOTTOM);
        end else if (wmode == TMC_WM_FAST_OCR) begin
            ovf_at = at_top;
        end else begin
            ovf_at = tick && (r_reg.cnt == TMC_MAX);
        end
        wr_cnt = wr_i && addr_ok && (eff_addr == TMC_ADDR_CNT);
        frc_a = wr_i && addr_ok && (eff_addr == TMC_ADDR_CTRL_B)
                && wdata_i[TMC_FOCA_BIT] && (cls == TMC_CLS_PLAIN);
        frc_b = wr_i && addr_ok && (eff_addr == TMC_ADDR_CTRL_B)
                && wdata_i[TMC_FOCB_BIT] && (cls == TMC_CLS_PLAIN);
        flag_clr = irq_ack_i;
        if (wr_i && addr_ok && eff_addr == TMC_ADDR_FLAG) begin
            flag_clr = irq_ack_i | wdata_i[2:0];
        end
        // Forced compares never reach the flags.
        flag_set = '0;
        flag_set[TMC_FLAG_OVF] = ovf_at;
        flag_set[TMC_FLAG_MA] = hit_a;
        flag_set[TMC_FLAG_MB] = hit_b;
    end

    always_comb begin
        r_next = r_reg;
        // Counter sequencing; only channel A clears it on match.
        if (tick) begin
            if (cls == TMC_CLS_PHASE) begin
                if (!r_reg.dir_down) begin
                    if (r_reg.cnt == top) begin
                        r_next.dir_down = 1'b1;
                        r_next.cnt = r_reg.cnt - 1'b1;
                    end else begin
                        r_next.cnt = r_reg.cnt + 1'b1;
                    end
                end else if (r_reg.cnt == TMC_BOTTOM) begin
                    r_next.dir_down = 1'b0;
                    r_next.cnt = r_reg.cnt + 1'b1;
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end else begin
                r_next.dir_down = 1'b0;
                r_next.cnt = (r_reg.cnt == top) ? TMC_BOTTOM
                                                : r_reg.cnt + 1'b1;
            end
            r_next.blk = 1'b0;
        end
        r_next.out_a = wave_next(r_reg.ctrl_a[TMC_COMA_LO +: 2],
                                 r_reg.ctrl_b[TMC_WGM2_BIT], cls,
                                 r_reg.out_a, hit_a, frc_a, at_top,
                                 !r_reg.dir_down,
                                 r_reg.ocra == top);
        r_next.out_b = wave_next(r_reg.ctrl_a[TMC_COMB_LO +: 2], 1'b0, cls,
                                 r_reg.out_b, hit_b, frc_b, at_top,
                                 !r_reg.dir_down,
                                 r_reg.ocrb == top);
        r_next.flags = (r_reg.flags & ~flag_clr) | flag_set;
        if (wr_i && addr_ok) begin
            unique case (eff_addr)
                TMC_ADDR_CTRL_A: r_next.ctrl_a = wdata_i;
                TMC_ADDR_CTRL_B: r_next.ctrl_b = wdata_i[3:0];
                TMC_ADDR_OCRA: r_next.ocra_buf = wdata_i;
                TMC_ADDR_OCRB: r_next.ocrb_buf = wdata_i;
                TMC_ADDR_MASK: r_next.mask = wdata_i[2:0];
                TMC_ADDR_CNT: begin
                    r_next.cnt = wdata_i;
                    r_next.blk = 1'b1;
                end
                default: r_next.mask = r_next.mask;
            endcase
        end
        // Compare double buffering: immediate in non-PWM modes, at TOP in PWM modes.
        if (cls == TMC_CLS_PLAIN || (at_top && cls != TMC_CLS_PLAIN)) begin
            r_next.ocra = r_next.ocra_buf;
            r_next.ocrb = r_next.ocrb_buf;
        end
        r_next.en_a = r_next.ctrl_a[TMC_COMA_LO +: 2] != 2'b00;
        r_next.en_b = r_next.ctrl_a[TMC_COMB_LO +: 2] != 2'b00;
        r_next.irq = r_next.flags & r_next.mask
                     & {3{global_irq_en_i}};
        if (rd_i && addr_ok) begin
            unique case (eff_addr)
                TMC_ADDR_CTRL_A: r_next.rdata = r_reg.ctrl_a;
                TMC_ADDR_CTRL_B: r_next.rdata = {4'h0, r_reg.ctrl_b};
                TMC_ADDR_CNT: r_next.rdata = r_reg.cnt;
                TMC_ADDR_OCRA: r_next.rdata = r_reg.ocra_buf;
                TMC_ADDR_OCRB: r_next.rdata = r_reg.ocrb_buf;
                TMC_ADDR_FLAG: r_next.rdata = {5'h00, r_reg.flags};
                TMC_ADDR_MASK: r_next.rdata = {5'h00, r_reg.mask};
                default: r_next.rdata = TMC_BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_reg.ctrl_a <= TMC_CTRL_A_RESET;
            r_reg.ctrl_b <= TMC_CTRL_B_RESET;
            r_reg.cnt <= TMC_BYTE_RESET;
            r_reg.ocra_buf <= TMC_BYTE_RESET;
            r_reg.ocrb_buf <= TMC_BYTE_RESET;
            r_reg.ocra <= TMC_BYTE_RESET;
            r_reg.ocrb <= TMC_BYTE_RESET;
            r_reg.flags <= TMC_BITS3_RESET;
            r_reg.mask <= TMC_BITS3_RESET;
            r_reg.dir_down <= 1'b0;
            r_reg.blk <= 1'b0;
            r_reg.out_a <= 1'b0;
            r_reg.out_b <= 1'b0;
            r_reg.en_a <= 1'b0;
            r_reg.en_b <= 1'b0;
            r_reg.irq <= TMC_BITS3_RESET;
            r_reg.rdata <= TMC_BYTE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata_o = r_reg.rdata;
    assign irq_o = r_reg.irq;
    assign wave_out_a_o = r_reg.out_a;
    assign wave_out_b_o = r_reg.out_b;
    assign wave_a_override_o = r_reg.en_a;
    assign wave_b_override_o = r_reg.en_b;

    a_force_reads_zero:
    assert property (@(posedge clk_i) disable iff (srst_i)
        rd_i && !io_space_i && addr_i == TMC_ADDR_CTRL_B
        |=> rdata_o[7:6] == 2'b00)
    else $error("force bits read back nonzero");

    a_stopped_holds:
    assert property (@(posedge clk_i) disable iff (srst_i)
        cs == TMC_CS_STOP && !wr_cnt |=> $stable(r_reg.cnt))
    else $error("counter moved with no clock source");

    a_force_b_set:
    assert property (@(posedge clk_i) disable iff (srst_i)
        frc_b && r_reg.ctrl_a[5:4] == 2'b11 |=> wave_out_b_o)
    else $error("forced compare did not set channel B");

    a_force_no_flag:
    assert property (@(posedge clk_i) disable iff (srst_i)
        frc_b && !hit_b && !r_reg.flags[TMC_FLAG_MB]
        |=> !r_reg.flags[TMC_FLAG_MB])
    else $error("forced compare raised a flag");

    a_fast_b_clear:
    assert property (@(posedge clk_i) disable iff (srst_i)
        cls == TMC_CLS_FAST && hit_b && r_reg.ctrl_a[5:4] == 2'b10
        && r_reg.ocrb != top |=> !wave_out_b_o)
    else $error("fast mode did not clear channel B on match");

    a_phase_b_up:
    assert property (@(posedge clk_i) disable iff (srst_i)
        cls == TMC_CLS_PHASE && hit_b && !r_reg.dir_down
        && r_reg.ctrl_a[5:4] == 2'b11 && r_reg.ocrb != top
        |=> wave_out_b_o)
    else $error("phase mode did not set channel B on up match");

    a_ovf_normal_max:
    assert property (@(posedge clk_i) disable iff (srst_i)
        wmode == TMC_WM_NORMAL && tick && r_reg.cnt == TMC_MAX
        |=> r_reg.flags[TMC_FLAG_OVF] && (irq_o[TMC_FLAG_OVF]
            || !r_reg.mask[TMC_FLAG_OVF] || !$past(global_irq_en_i)))
    else $error("overflow at MAX not flagged");

    a_io_alias:
    assert property (@(posedge clk_i) disable iff (srst_i)
        wr_i && io_space_i && addr_i == TMC_ADDR_CTRL_B - TMC_IO_OFFSET
        |=> {4'h0, r_reg.ctrl_b} == ($past(wdata_i) & 8'h0f))
    else $error("I/O alias of control B not written");

    a_ack_clears:
    assert property (@(posedge clk_i) disable iff (srst_i)
        irq_ack_i[TMC_FLAG_MA] && !hit_a |=> !r_reg.flags[TMC_FLAG_MA])
    else $error("acknowledge did not clear match A flag");

    a_irq_gate:
    assert property (@(posedge clk_i) disable iff (srst_i)
        irq_o != 3'h0 |-> $past(global_irq_en_i))
    else $error("interrupt raised without global enable");

    a_ext_rise_counts:
    assert property (@(posedge clk_i) disable iff (srst_i)
        cs == TMC_CS_EXT_RISE && !ext_rise && !wr_cnt
        |=> $stable(r_reg.cnt))
    else $error("counter moved without a pin edge");
endmodule
`default_nettype wire
